// ---- core/asp_core.sv ----
// audio serial port: APB registers, bit clock divider and link shifters
`timescale 1ns/100ps
module asp_core
   import asp_pkg::*;
(
   input  logic        sys_clk,
   input  logic        rst,
   input  logic        link_clk,
   input  logic [7:0]  paddr,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   output logic        sclk_o,
   output logic        sclk_oe,
   input  logic        fs_i,
   output logic        fs_o,
   output logic        fs_oe,
   input  logic [1:0]  data_i,
   output logic [1:0]  data_o,
   output logic [1:0]  data_oe,
   output logic [1:0]  dma_req,
   output logic        err_irq
);

   asp_cfg_type  ctrl;
   logic [4:0]   wlen;
   logic [6:0]   slots_m1;
   logic [15:0]  fbits_m1;
   logic [15:0]  clkdiv;
   logic         err_flag;
   logic         errt_m;
   logic         errt_s;
   logic         errt_p;
   logic         link_off;
   logic         link_rst;
   logic [4:0]   wl_eff;
   logic [4:0]   next_wl;
   logic [15:0]  div_cnt;
   logic [15:0]  half_m1;
   logic [31:0]  next_rdata;
   logic         next_slverr;
   logic         stereo;
   logic [31:0]  tx_word [ASP_LINES];
   logic [31:0]  rx_data [ASP_LINES];
   logic         tx_req  [ASP_LINES];
   logic         rx_full [ASP_LINES];
   logic         dq      [ASP_LINES];
   wire  [1:0]   tx_full;

   logic         lo_m;
   logic         lo_s;
   logic         lr_m;
   logic         lr_s;
   logic         fs_r;
   logic [1:0]   din_r;
   logic         fs_prev;
   logic         active;
   logic         lag;
   logic         errt;
   logic [15:0]  fcnt;
   logic [15:0]  fhalf;
   logic [4:0]   bitc;
   logic [6:0]   words;
   logic [31:0]  rx_hold [ASP_LINES];
   logic         dout    [ASP_LINES];
   logic         doe     [ASP_LINES];
   logic         fs_lvl;
   logic         start;
   logic         shift_en;
   logic         first;
   logic         last;

   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready & pwrite;
   wire rd_en = psel & penable & pready & ~pwrite;

   function automatic logic [7:0] asp_enc(input logic [15:0] s, input logic alaw);
      logic [15:0] mag;
      logic [13:0] m;
      logic [13:0] sh;
      logic [3:0]  p;
      logic [2:0]  e;
      mag = s[15] ? 16'(~s + 16'h0001) : s;
      if (alaw)
         m = ({1'b0, mag[15:3]} > ASP_A_CLIP) ? ASP_A_CLIP : {1'b0, mag[15:3]};
      else
         m = (mag[15:2] > ASP_MU_CLIP) ? ASP_MU_MAX : 14'(mag[15:2] + ASP_MU_BIAS);
      p = 4'h0;
      for (int k = 5; k < 13; k++) begin
         if (m[k])
            p = 4'(k);
      end
      sh = m >> (p - 4'h4);
      e = 3'(p - (alaw ? 4'h4 : 4'h5));
      if (p == 4'h0) begin
         e = 3'h0;
         sh = m >> 1;
      end
      if (alaw)
         return {~s[15], e, sh[3:0]} ^ ASP_A_XOR;
      return ~{s[15], e, sh[3:0]};
   endfunction : asp_enc

   function automatic logic [15:0] asp_dec(input logic [7:0] c, input logic alaw);
      logic [7:0]  u;
      logic [15:0] t;
      u = alaw ? (c ^ ASP_A_XOR) : ~c;
      if (!alaw)
         t = (((16'(u[3:0]) << 3) + ASP_MU_DBIAS) << u[6:4]) - ASP_MU_DBIAS;
      else if (u[6:4] == 3'h0)
         t = (16'(u[3:0]) << 4) + ASP_A_DSEG0;
      else
         t = ((16'(u[3:0]) << 4) + ASP_A_DBIAS) << (u[6:4] - 3'h1);
      if (alaw ? ~u[7] : u[7])
         t = 16'(~t + 16'h0001);
      return t;
   endfunction : asp_dec

   // apb: one wait-free access phase, read data latched in the setup cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata  <= next_rdata;
            pslverr <= next_slverr;
         end
      end
   end

   always_comb begin
      next_rdata  = 32'h0;
      next_slverr = 1'b0;
      if (paddr == ASP_OFS_CTRL)
         next_rdata = 32'(ctrl);
      else if (paddr == ASP_OFS_WLEN)
         next_rdata = 32'(wlen);
      else if (paddr == ASP_OFS_FRAME) begin
         next_rdata[ASP_SLOT_LSB +: ASP_SLOT_W]   = slots_m1;
         next_rdata[ASP_FBITS_LSB +: ASP_FBITS_W] = fbits_m1;
      end else if (paddr == ASP_OFS_CLKDIV)
         next_rdata = 32'(clkdiv);
      else if (paddr == ASP_OFS_STATUS) begin
         next_rdata[ASP_ST_ERR]      = err_flag;
         next_rdata[ASP_ST_TXF +: 2] = tx_full;
         next_rdata[ASP_ST_RXF +: 2] = {rx_full[1], rx_full[0]};
      end else if (paddr == ASP_OFS_DATA0)
         next_rdata = rx_data[0];
      else if (paddr == ASP_OFS_DATA1)
         next_rdata = rx_data[1];
      else
         next_slverr = 1'b1;
   end

   // link side reads these directly: change them only while disabled
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl     <= '0;
         wlen     <= ASP_WLEN_RST;
         slots_m1 <= ASP_SLOT_RST;
         fbits_m1 <= ASP_FBITS_RST;
         clkdiv   <= ASP_DIV_RST;
      end else if (wr_en) begin
         if (paddr == ASP_OFS_CTRL)
            ctrl <= asp_cfg_type'(pwdata[ASP_CFG_W-1:0]);
         else if (paddr == ASP_OFS_WLEN)
            wlen <= pwdata[4:0];
         else if (paddr == ASP_OFS_FRAME) begin
            slots_m1 <= pwdata[ASP_SLOT_LSB +: ASP_SLOT_W];
            fbits_m1 <= pwdata[ASP_FBITS_LSB +: ASP_FBITS_W];
         end else if (paddr == ASP_OFS_CLKDIV)
            clkdiv <= pwdata[15:0];
      end
   end

   always_comb begin
      stereo  = ctrl.mode inside {ASP_I2S, ASP_PKI2S, ASP_LJ};
      next_wl = wlen;
      if (next_wl < ASP_WL_MIN_M1)
         next_wl = ASP_WL_MIN_M1;
      if (stereo && next_wl < ASP_WL_STEREO_M1)
         next_wl = ASP_WL_STEREO_M1;
   end

   // error toggle from the link becomes a sticky flag, write one to clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         errt_m   <= 1'b0;
         errt_s   <= 1'b0;
         errt_p   <= 1'b0;
         err_flag <= 1'b0;
         err_irq  <= 1'b0;
         link_off <= 1'b1;
         link_rst <= 1'b1;
         wl_eff   <= ASP_WL_MIN_M1;
      end else begin
         errt_m <= errt;
         errt_s <= errt_m;
         errt_p <= errt_s;
         if (errt_s ^ errt_p)
            err_flag <= 1'b1;
         else if (wr_en && paddr == ASP_OFS_STATUS && pwdata[ASP_ST_ERR])
            err_flag <= 1'b0;
         err_irq  <= err_flag;
         link_off <= ~ctrl.en;
         link_rst <= 1'b0;
         wl_eff   <= next_wl;
      end
   end

   // bit clock generator; a half period never drops below two clocks
   assign half_m1 = ((clkdiv < ASP_MIN_HALF) ? ASP_MIN_HALF : clkdiv) - 16'h0001;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt <= 16'h0;
         sclk_o  <= 1'b0;
         sclk_oe <= 1'b0;
      end else begin
         sclk_oe <= ctrl.en & ctrl.clk_int;
         if (!(ctrl.en && ctrl.clk_int)) begin
            div_cnt <= 16'h0;
            sclk_o  <= 1'b0;
         end else if (div_cnt >= half_m1) begin
            div_cnt <= 16'h0;
            sclk_o  <= ~sclk_o;
         end else
            div_cnt <= div_cnt + 16'h0001;
      end
   end

   // link domain resets: disable and hard reset carried over separately
   always_ff @(posedge link_clk) begin
      lo_m <= link_off;
      lo_s <= lo_m;
      lr_m <= link_rst;
      lr_s <= lr_m;
   end

   // pins are already synchronous to the link clock, one sample stage only
   always_ff @(posedge link_clk) begin
      if (lo_s) begin
         fs_r  <= 1'b0;
         din_r <= 2'h0;
      end else begin
         fs_r  <= fs_i;
         din_r <= data_i;
      end
   end

   assign fhalf = 16'((17'(fbits_m1) + 17'h00001) >> 1);

   always_ff @(posedge link_clk) begin
      if (lo_s) begin
         fcnt  <= 16'h0;
         fs_o  <= 1'b0;
         fs_oe <= 1'b0;
      end else begin
         fs_oe <= ctrl.fs_int;
         fcnt  <= (fcnt >= fbits_m1) ? 16'h0 : fcnt + 16'h0001;
         if (stereo)
            fs_o <= (fcnt >= fhalf);
         else
            fs_o <= (fcnt == fbits_m1);
      end
   end

   always_comb begin
      fs_lvl   = ctrl.fs_int ? fs_o : fs_r;
      start    = stereo ? (fs_lvl ^ fs_prev) : (fs_lvl & ~fs_prev);
      shift_en = active & ~lag;
      first    = shift_en & (bitc == 5'h0);
      last     = shift_en & (bitc == wl_eff);
   end

   always_ff @(posedge link_clk) begin
      if (lr_s)
         errt <= 1'b0;
      else if (!lo_s && start && active && !(last && words == 7'h0))
         errt <= ~errt;
   end

   always_ff @(posedge link_clk) begin
      if (lo_s) begin
         fs_prev <= 1'b0;
         active  <= 1'b0;
         lag     <= 1'b0;
         bitc    <= 5'h0;
         words   <= 7'h0;
      end else begin
         fs_prev <= fs_lvl;
         if (start) begin
            active <= 1'b1;
            lag    <= (ctrl.mode != ASP_LJ);
            bitc   <= 5'h0;
            words  <= (ctrl.mode inside {ASP_TDM, ASP_PKI2S}) ? slots_m1 : 7'h0;
         end else if (lag)
            lag <= 1'b0;
         else if (active) begin
            if (bitc == wl_eff) begin
               bitc <= 5'h0;
               if (words == 7'h0)
                  active <= 1'b0;
               else
                  words <= words - 7'h01;
            end else
               bitc <= bitc + 5'h01;
         end
      end
   end

   for (genvar i = 0; i < ASP_LINES; i++) begin : g_line
      logic        ack_m;
      logic        ack_s;
      logic        rxt_m;
      logic        rxt_s;
      logic        rxt_p;
      logic        fresh;
      logic        req_m;
      logic        req_s;
      logic        ack;
      logic        rxt;
      logic [31:0] sr;
      logic [31:0] rsr;
      logic [31:0] cur;
      logic [31:0] nrsr;
      logic [31:0] ld;
      logic [15:0] dec;

      wire is_tx = ctrl.dir[i];
      wire comp  = ctrl.comp[i][ASP_COMP_ON];
      wire alaw  = ctrl.comp[i][ASP_COMP_ALAW];
      wire wr    = wr_en && (paddr == ((i == 0) ? ASP_OFS_DATA0 : ASP_OFS_DATA1));
      wire rd    = rd_en && (paddr == ((i == 0) ? ASP_OFS_DATA0 : ASP_OFS_DATA1));
      wire rx_ev = rxt_s ^ rxt_p;

      assign tx_full[i] = tx_req[i] ^ ack_s;
      assign dec        = asp_dec(rx_hold[i][7:0], alaw);

      // full data words cross by toggle handshake; writes while full are dropped
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            ack_m      <= 1'b0;
            ack_s      <= 1'b0;
            rxt_m      <= 1'b0;
            rxt_s      <= 1'b0;
            rxt_p      <= 1'b0;
            fresh      <= 1'b0;
            tx_req[i]  <= 1'b0;
            tx_word[i] <= 32'h0;
            rx_data[i] <= 32'h0;
            rx_full[i] <= 1'b0;
            dq[i]      <= 1'b0;
         end else begin
            ack_m <= ack;
            ack_s <= ack_m;
            rxt_m <= rxt;
            rxt_s <= rxt_m;
            rxt_p <= rxt_s;
            fresh <= rx_ev | (fresh & ~setup);
            if (wr && !tx_full[i]) begin
               tx_req[i]  <= ~tx_req[i];
               tx_word[i] <= comp ? {24'h0, asp_enc(pwdata[15:0], alaw)} : pwdata;
            end
            if (rx_ev) begin
               rx_full[i] <= 1'b1;
               rx_data[i] <= comp ? {{16{dec[15]}}, dec} : rx_hold[i];
            end else if (rd && !fresh)
               rx_full[i] <= 1'b0;
            dq[i] <= ctrl.en & (is_tx ? ~tx_full[i] : rx_full[i]);
         end
      end

      always_comb begin
         ld   = (req_s ^ ack) ? tx_word[i] : 32'h0;
         cur  = first ? (ctrl.big ? ld << (5'd31 - wl_eff) : ld) : sr;
         nrsr = ctrl.big ? {rsr[30:0], din_r[i]} : {din_r[i], rsr[31:1]};
      end

      always_ff @(posedge link_clk) begin
         if (lr_s) begin
            req_m      <= 1'b0;
            req_s      <= 1'b0;
            ack        <= 1'b0;
            rxt        <= 1'b0;
            rx_hold[i] <= 32'h0;
         end else begin
            req_m <= tx_req[i];
            req_s <= req_m;
            if (first && is_tx && (req_s ^ ack))
               ack <= ~ack;
            if (last && !is_tx) begin
               // msb-first keeps older bits above the word, so mask them off
               rx_hold[i] <= ctrl.big ? nrsr & (32'hFFFFFFFF >> (5'd31 - wl_eff))
                                      : nrsr >> (5'd31 - wl_eff);
               rxt        <= ~rxt;
            end
         end
      end

      // underrun sends zeros; idle line keeps its last level
      always_ff @(posedge link_clk) begin
         if (lo_s) begin
            sr      <= 32'h0;
            rsr     <= 32'h0;
            dout[i] <= 1'b0;
            doe[i]  <= 1'b0;
         end else begin
            doe[i] <= is_tx;
            if (shift_en && is_tx) begin
               dout[i] <= ctrl.big ? cur[31] : cur[0];
               sr      <= ctrl.big ? cur << 1 : cur >> 1;
            end
            if (shift_en && !is_tx)
               rsr <= nrsr;
         end
      end
   end

   assign data_o  = {dout[1], dout[0]};
   assign data_oe = {doe[1], doe[0]};
   assign dma_req = {dq[1], dq[0]};

endmodule : asp_core

// ---- core/asp_pkg.sv ----
// audio serial port package: register map, fields, resets and timing
// What this block does
// - two data lines, one bit clock, one sync
// - bit rate at most a quarter of clock
// - paired ports share clock and frame sync
// - five selectable framing modes
// - up to 128 slots per TDM frame
// - left-justified: one word per sync level
// - I2S and left-justified: four channels over two lines
// - selectable little or big endian order
// - word length from 3 to 32 bits
// - stereo modes: word length 8 to 32
// - per-line mu-law or A-law companding
// - clock and sync internal or external
// - flag frame sync arriving during a word
// - frame sync errors merged onto one output
package asp_pkg;

   typedef enum logic [2:0] {ASP_STD, ASP_TDM, ASP_I2S, ASP_PKI2S, ASP_LJ} asp_mode_type;

   typedef struct packed {
      logic             fs_int;
      logic             clk_int;
      logic [1:0][1:0]  comp;
      logic [1:0]       dir;
      logic             big;
      asp_mode_type     mode;
      logic             en;
   } asp_cfg_type;

   localparam int          ASP_CFG_W        = $bits(asp_cfg_type);
   localparam int          ASP_LINES        = 2;

   localparam logic [7:0]  ASP_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  ASP_OFS_WLEN     = 8'h04;
   localparam logic [7:0]  ASP_OFS_FRAME    = 8'h08;
   localparam logic [7:0]  ASP_OFS_CLKDIV   = 8'h0C;
   localparam logic [7:0]  ASP_OFS_STATUS   = 8'h10;
   localparam logic [7:0]  ASP_OFS_DATA0    = 8'h14;
   localparam logic [7:0]  ASP_OFS_DATA1    = 8'h18;

   localparam int          ASP_SLOT_LSB     = 0;
   localparam int          ASP_SLOT_W       = 7;
   localparam int          ASP_FBITS_LSB    = 8;
   localparam int          ASP_FBITS_W      = 16;
   localparam int          ASP_ST_ERR       = 0;
   localparam int          ASP_ST_TXF       = 1;
   localparam int          ASP_ST_RXF       = 3;
   localparam int          ASP_COMP_ON      = 1;
   localparam int          ASP_COMP_ALAW    = 0;

   localparam logic [4:0]  ASP_WLEN_RST     = 5'h0F;
   localparam logic [6:0]  ASP_SLOT_RST     = 7'h00;
   localparam logic [15:0] ASP_FBITS_RST    = 16'h003F;
   localparam logic [15:0] ASP_DIV_RST      = 16'h0002;
   localparam logic [4:0]  ASP_WL_MIN_M1    = 5'h02;
   localparam logic [4:0]  ASP_WL_STEREO_M1 = 5'h07;

   localparam int          ASP_SYS_PERIOD_NS   = 5;
   localparam int          ASP_MIN_SYS_PER_BIT = 4;
   localparam logic [15:0] ASP_MIN_HALF        = 16'(ASP_MIN_SYS_PER_BIT / 2);

   localparam logic [13:0] ASP_MU_BIAS      = 14'h0021;
   localparam logic [13:0] ASP_MU_CLIP      = 14'h1FDE;
   localparam logic [13:0] ASP_MU_MAX       = 14'h1FFF;
   localparam logic [13:0] ASP_A_CLIP       = 14'h0FFF;
   localparam logic [7:0]  ASP_A_XOR        = 8'h55;
   localparam logic [15:0] ASP_MU_DBIAS     = 16'h0084;
   localparam logic [15:0] ASP_A_DBIAS      = 16'h0108;
   localparam logic [15:0] ASP_A_DSEG0      = 16'h0008;

endpackage : asp_pkg

// ---- verif/asp_core_checker.sv ----
// checker for the audio serial port top: apb handshake, bit clock rate, error flag, dma requests
`timescale 1ns/100ps
module asp_core_checker
   import asp_pkg::*;
(
   input logic        sys_clk,
   input logic        rst,
   input logic        link_clk,
   input logic [7:0]  paddr,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        sclk_o,
   input logic        sclk_oe,
   input logic        fs_i,
   input logic        fs_o,
   input logic        fs_oe,
   input logic [1:0]  data_i,
   input logic [1:0]  data_o,
   input logic [1:0]  data_oe,
   input logic [1:0]  dma_req,
   input logic        err_irq
);
   logic st_clr;
   logic wr0;
   assign st_clr = psel && penable && pready && pwrite && paddr == ASP_OFS_STATUS && pwdata[0];
   assign wr0    = psel && penable && pready && pwrite && paddr == ASP_OFS_DATA0;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   rst_quiet_a: assert property ($fell(rst) |-> dma_req == 2'h0 && !err_irq && !pready && !sclk_oe)
      else $error("outputs not quiet after reset");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   unmapped_err_a: assert property (psel && !penable && paddr > ASP_OFS_DATA1 |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   clk_rate_a: assert property ($changed(sclk_o) && sclk_oe |=> $stable(sclk_o) || !sclk_oe)
      else $error("bit clock half period under two cycles");
   sclk_idle_a: assert property (!sclk_oe && !$past(sclk_oe) && !$past(sclk_oe, 2) |-> $stable(sclk_o))
      else $error("bit clock moves while not generated");
   err_sticky_a: assert property (err_irq && !st_clr && !$past(st_clr) |=> err_irq)
      else $error("error flag dropped without clear");
   tx_req_a: assert property (wr0 && dma_req[0] && data_oe[0] |-> ##[1:3] !dma_req[0])
      else $error("tx request kept after write");

   cover property ($rose(err_irq));
   cover property (wr0 && dma_req[0]);
   cover property ($rose(sclk_oe));
endmodule : asp_core_checker

bind asp_core asp_core_checker u_chk (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs_i(fs_i), .fs_o(fs_o), .fs_oe(fs_oe),
   .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .dma_req(dma_req), .err_irq(err_irq));

// ---- verif/asp_codec_model.sv ----
// codec model: bit clock, frame sync and serial data at the far side
`timescale 1ns/100ps
module asp_codec_model (
   input  logic        go,
   input  logic [4:0]  half,
   input  logic [15:0] rx_bits,
   input  logic [1:0]  dout,
   output logic        lclk,
   output logic        fs,
   output logic [1:0]  din,
   output logic [15:0] cap
);
   int i;
   initial begin
      lclk = 1'b0;
      fs = 1'b0;
      din = 2'h2;
      cap = 16'h0000;
   end
   // clock only within frames; idle data lines toggle so stale bits never look valid
   always @(posedge go) begin
      for (i = 0; i < 2 * half + 6; i++) begin
         fs <= (i < half);
         din[0] <= ~din[0];
         // receiver takes bits from one clock after the sync edge, transmitter answers two later
         if (i >= 1 && i < 17)
            din[1] <= rx_bits[16 - i];
         else
            din[1] <= ~din[1];
         if (i >= 3 && i < 19)
            cap <= {cap[14:0], dout[0]};
         #32 lclk = 1'b1;
         #32 lclk = 1'b0;
      end
   end
endmodule : asp_codec_model

// ---- verif/asp_core_test.sv ----
// testbench for the audio serial port: registers, bit clock, left-justified traffic, frame sync errors
`timescale 1ns/100ps
module asp_core_test;
   import asp_pkg::*;
   logic        sys_clk, rst, psel, penable, pwrite, go, err, sclk_o, sclk_oe, fs_o, fs_oe, err_irq, lclk, fs, p;
   logic        pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, ctl;
   logic [1:0]  data_o, data_oe, dma_req, din;
   logic [4:0]  half;
   logic [15:0] rx_bits, cap;
   wire         link_clk;
   int          fails, n_tests, b, m, t, k;

   assign link_clk = sclk_oe ? sclk_o : lclk;

   asp_core dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs_i(fs), .fs_o(fs_o), .fs_oe(fs_oe),
      .data_i(din), .data_o(data_o), .data_oe(data_oe), .dma_req(dma_req), .err_irq(err_irq));
   asp_codec_model u_codec (.go(go), .half(half), .rx_bits(rx_bits), .dout(data_o), .lclk(lclk), .fs(fs),
      .din(din), .cap(cap));

   always #2.5 sys_clk = ~sys_clk;

   function automatic logic [7:0] rev8(input logic [7:0] x);
      for (int j = 0; j < 8; j++) rev8[j] = x[7 - j];
   endfunction : rev8

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", e, rd);
   endtask : rd_chk

   task wait_dma(input int i, input logic v);
      int n;
      n = 0;
      while (dma_req[i] !== v && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      chk("dma_req", {31'h0, v}, {31'h0, dma_req[i]});
   endtask : wait_dma

   task launch(input logic [4:0] h);
      half <= h;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
   endtask : launch

   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   initial begin
      repeat (30000) @(posedge sys_clk);
      fails++;
      summarize;
   end

   initial begin
      sys_clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; fails = 0; n_tests = 0; rx_bits = 16'h1E2D; half = 5'h01; go = 1'b0;
      // longer than usual: the link domain needs three link edges in reset
      @(posedge sys_clk);
      go <= 1'b1;
      repeat (63) @(posedge sys_clk);
      rst <= 1'b0;
      go <= 1'b0;
      rd_chk(ASP_OFS_CTRL, 32'h0);
      rd_chk(ASP_OFS_WLEN, 32'h0F);
      rd_chk(ASP_OFS_FRAME, {8'h00, ASP_FBITS_RST, 1'b0, ASP_SLOT_RST});
      rd_chk(ASP_OFS_CLKDIV, 32'h2);
      rd_chk(ASP_OFS_STATUS, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      chk("unmapped", 32'h0, rd);
      for (m = 0; m < 5; m++) begin
         apb(1'b1, ASP_OFS_CTRL, m << 1);
         rd_chk(ASP_OFS_CTRL, m << 1);
      end
      apb(1'b1, ASP_OFS_WLEN, 32'h7);
      rd_chk(ASP_OFS_WLEN, 32'h7);
      apb(1'b1, ASP_OFS_CLKDIV, 32'h0);
      apb(1'b1, ASP_OFS_CTRL, 32'h801);
      repeat (4) @(posedge sys_clk);
      chk("sclk_oe", 32'h1, {31'h0, sclk_oe});
      t = 0;
      p = sclk_o;
      for (k = 0; k < 40; k++) begin
         @(posedge sys_clk);
         if (sclk_o !== p) t++;
         p = sclk_o;
      end
      chk("sclk_edges", 32'd20, t);
      apb(1'b1, ASP_OFS_CTRL, 32'h0);
      repeat (4) @(posedge sys_clk);
      chk("sclk_oe", 32'h0, {31'h0, sclk_oe});
      for (b = 1; b >= 0; b--) begin
         ctl = 32'h29 | (b << 4);
         apb(1'b1, ASP_OFS_CTRL, {ctl[31:1], 1'b0});
         apb(1'b1, ASP_OFS_CTRL, ctl);
         apb(1'b1, ASP_OFS_DATA0, 32'hA5);
         repeat (2) @(posedge sys_clk);
         launch(5'd8);
         wait_dma(0, 1'b1);
         apb(1'b1, ASP_OFS_DATA0, 32'h3C);
         wait_dma(1, 1'b1);
         apb(1'b0, ASP_OFS_DATA1, 32'h0);
         chk("rx_word0", b ? 32'h1E : {24'h0, rev8(8'h1E)}, rd);
         wait_dma(1, 1'b0);
         wait_dma(1, 1'b1);
         apb(1'b0, ASP_OFS_DATA1, 32'h0);
         chk("rx_word1", b ? 32'h2D : {24'h0, rev8(8'h2D)}, rd);
         repeat (300) @(posedge sys_clk);
         chk("tx_words", b ? 32'hA53C : {16'h0, rev8(8'hA5), rev8(8'h3C)}, {16'h0, cap});
         chk("data_oe", 32'h1, {30'h0, data_oe});
         apb(1'b1, ASP_OFS_CTRL, 32'h0);
      end
      apb(1'b1, ASP_OFS_CTRL, 32'h39);
      apb(1'b1, ASP_OFS_DATA0, 32'hA5);
      launch(5'd3);
      repeat (200) @(posedge sys_clk);
      apb(1'b0, ASP_OFS_STATUS, 32'h0);
      chk("status_err", 32'h1, {31'h0, rd[ASP_ST_ERR]});
      chk("err_irq", 32'h1, {31'h0, err_irq});
      apb(1'b1, ASP_OFS_STATUS, 32'h1);
      repeat (3) @(posedge sys_clk);
      apb(1'b0, ASP_OFS_STATUS, 32'h0);
      chk("status_err", 32'h0, {31'h0, rd[ASP_ST_ERR]});
      chk("err_irq", 32'h0, {31'h0, err_irq});
      // internal sync on the internal clock: square wave of 64 bits, two frames counted
      apb(1'b1, ASP_OFS_CTRL, 32'h1809);
      repeat (64) @(posedge sys_clk);
      chk("fs_oe", 32'h1, {31'h0, fs_oe});
      t = 0;
      p = fs_o;
      for (k = 0; k < 512; k++) begin
         @(posedge sys_clk);
         if (fs_o !== p) t++;
         p = fs_o;
      end
      chk("fs_edges", 32'd4, t);
      summarize;
   end
endmodule : asp_core_test
